// ==== design/fem_spi_pkg.sv ====
// Constants shared by the serial register port of the front-end module.
// Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
package fem_spi_pkg;

  // Frame layout
  localparam int CMD_W = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_DATA_LOAD = 5'h08;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

  // Command codes
  localparam logic [CMD_W-1:0] CMD_READ = 2'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE = 2'h3;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_OTP_A = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_OTP_B = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_PART_CODE = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_REVISION = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_IDENT_LOW = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_IDENT_HIGH = 6'h17;

  // Reset value of the writable registers
  localparam logic [DATA_W-1:0] RESET_CFG = 8'h00;
  // Revision bits readable in every state
  localparam logic [DATA_W-1:0] REV_OPEN_MASK = 8'h0f;

  // Operating state codes driven by the state machine outside
  localparam int ST_W = 3;
  localparam logic [ST_W-1:0] ST_POWER_DOWN = 3'h0;
  localparam logic [ST_W-1:0] ST_PROGRAM = 3'h1;
  localparam logic [ST_W-1:0] ST_RECEIVE = 3'h2;
  localparam logic [ST_W-1:0] ST_TRANSMIT = 3'h3;
  localparam logic [ST_W-1:0] ST_OTP_PROG = 3'h4;

endpackage

// ==== design/bit_sync.sv ====
// Two flip-flop synchroniser for one level into the system clock.
// Assumes the input is a level or toggle from another clock domain.
`timescale 1ns/1ps
module bit_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ==== design/spi_link.sv ====
// Serial clock side of the register port: bit counter, shifters, MISO.
// Assumes chip select frames each burst and the serial clock idles low.
`timescale 1ns/1ps
module spi_link
(
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [fem_spi_pkg::DATA_W-1:0] rd_word,
  output logic addr_ready,
  output logic wr_toggle,
  output logic [fem_spi_pkg::CMD_W-1:0] cmd,
  output logic [fem_spi_pkg::ADDR_W-1:0] addr,
  output logic [fem_spi_pkg::DATA_W-1:0] wdata
);

  logic [fem_spi_pkg::CNT_W-1:0] bit_cnt_r;
  logic [fem_spi_pkg::DATA_W-1:0] shift_r;
  logic [fem_spi_pkg::DATA_W-1:0] out_r;
  logic addr_ready_r;
  logic wr_toggle_r;
  logic [fem_spi_pkg::CMD_W-1:0] cmd_r;
  logic [fem_spi_pkg::ADDR_W-1:0] addr_r;
  logic [fem_spi_pkg::DATA_W-1:0] wdata_r;

  // Counter and input shifter; chip select high clears them at once
  always_ff @(posedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_cnt_r <= '0; // R19
      shift_r <= '0;
      addr_ready_r <= 1'b0;
    end
    else
    begin
      shift_r <= {shift_r[fem_spi_pkg::DATA_W-2:0], mosi}; // R2
      if (bit_cnt_r != fem_spi_pkg::CNT_FULL)
        bit_cnt_r <= bit_cnt_r + 5'h01; // R4
      if (bit_cnt_r == fem_spi_pkg::CNT_ADDR_LAST)
        addr_ready_r <= 1'b1; // R8
    end
  end

  // Fields held across the frame end for the system side
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      wr_toggle_r <= 1'b0;
    end
    else
    begin
      if (bit_cnt_r == fem_spi_pkg::CNT_ADDR_LAST)
        {cmd_r, addr_r} <= {shift_r[fem_spi_pkg::DATA_W-2:0], mosi}; // R5
      if (bit_cnt_r == fem_spi_pkg::CNT_LAST)
      begin
        wdata_r <= {shift_r[fem_spi_pkg::DATA_W-2:0], mosi}; // R6
        // Only a complete frame toggles; an early release aborts it
        wr_toggle_r <= ~wr_toggle_r; // R19
      end
    end
  end

  // Output shifter changes on falling edges; rd_word has settled by the
  // eighth falling edge, half a serial period after the address is known
  always_ff @(negedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
      out_r <= '0;
    else if (bit_cnt_r == fem_spi_pkg::CNT_DATA_LOAD)
      out_r <= rd_word; // R12 R13
    else
      out_r <= {out_r[fem_spi_pkg::DATA_W-2:0], 1'b0}; // R1 R11
  end

  assign miso = out_r[fem_spi_pkg::DATA_W-1];
  assign miso_oe = ~chip_select_n;
  assign addr_ready = addr_ready_r;
  assign wr_toggle = wr_toggle_r;
  assign cmd = cmd_r;
  assign addr = addr_r;
  assign wdata = wdata_r;

  AST_ADDR_AT_EIGHT: assert property ( // R8
    @(posedge sclk) disable iff (chip_select_n)
    (bit_cnt_r == fem_spi_pkg::CNT_ADDR_LAST) |=> addr_ready_r)
    else $error("address not ready after eighth rising edge");

  // Checked on the sixteenth falling edge: no rising edge follows it
  AST_FRAME_AT_SIXTEEN: assert property ( // R4
    @(negedge sclk) disable iff (chip_select_n)
    (bit_cnt_r == fem_spi_pkg::CNT_FULL &&
     $past(bit_cnt_r) == fem_spi_pkg::CNT_LAST) |->
      (wr_toggle_r != $past(wr_toggle_r)))
    else $error("sixteenth edge did not complete the frame");

  AST_DATA_MSB_FIRST: assert property ( // R6
    @(negedge sclk) disable iff (chip_select_n)
    (bit_cnt_r == fem_spi_pkg::CNT_FULL) |-> (wdata_r == shift_r))
    else $error("data byte not assembled msb first");

  AST_MISO_FIRST_BIT: assert property ( // R13
    @(posedge sclk) disable iff (chip_select_n)
    (bit_cnt_r == fem_spi_pkg::CNT_DATA_LOAD) |-> (miso == rd_word[7]))
    else $error("first data bit not on miso by ninth rising edge");

  AST_COUNT_BOUND: assert property ( // R19
    @(posedge sclk) disable iff (chip_select_n)
    bit_cnt_r <= fem_spi_pkg::CNT_FULL)
    else $error("bit counter ran past sixteen");

endmodule

// ==== design/fem_spi_register_port.sv ====
// Serial register port of the front-end module: link logic on the serial
// clock, register file and access control on the system clock.
// Assumes op_state comes from logic on sys_clk and the serial clock
// stands still outside frames.
//
// Operation
// (R1) Serial outputs change only on falling edges
// (R2) Mode zero: idle low, sample rising edges
// (R3) Master settles first bit before first edge
// (R4) Sixteen clocks per chip select frame
// (R5) Fields: command, address, then data
// (R6) All fields shifted most significant first
// (R7) Master keeps half-period select lead, trail
// (R8) Command, address, data on fixed edges
// (R9) Command 10 reads the addressed register
// (R10) Command 11 writes last eight data bits
// (R11) Write shifts out the previous value
// (R12) Writeback starts at falling edge eight
// (R13) Read data starts at falling edge eight
// (R14) Control registers reachable in four states
// (R15) Preset registers reachable only when programming
// (R16) Identity registers reachable only in program; the revision low nibble reads in every state
// (R17) Other commands change no register
// (R18) Unreachable register unchanged, reads as zero; the unreachable revision register reads its low nibble
// (R19) Early select release aborts, counter restarts
`timescale 1ns/1ps
module fem_spi_register_port
#(
  // Values of the read-only identity registers; arbitrary
  parameter logic [7:0] PART_CODE = 8'h5a,
  parameter logic [7:0] REVISION = 8'h21,
  parameter logic [7:0] IDENT_LOW = 8'h3c,
  parameter logic [7:0] IDENT_HIGH = 8'hc3
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [fem_spi_pkg::ST_W-1:0] op_state,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic [fem_spi_pkg::DATA_W-1:0] tx_control,
  output logic [fem_spi_pkg::DATA_W-1:0] rx_control,
  output logic [fem_spi_pkg::DATA_W-1:0] otp_preset_a,
  output logic [fem_spi_pkg::DATA_W-1:0] otp_preset_b
);

  logic [1:0] rst_pipe_r;
  logic rst_n;
  logic addr_ready;
  logic wr_toggle;
  logic [fem_spi_pkg::CMD_W-1:0] cmd;
  logic [fem_spi_pkg::ADDR_W-1:0] addr;
  logic [fem_spi_pkg::DATA_W-1:0] wdata;
  logic ar_sync;
  logic ar_last_r;
  logic wt_sync;
  logic wt_last_r;
  logic ar_evt;
  logic wr_evt;
  logic [fem_spi_pkg::DATA_W-1:0] rd_word_r;
  logic [fem_spi_pkg::DATA_W-1:0] rd_word_nxt;
  logic [fem_spi_pkg::DATA_W-1:0] tx_control_r;
  logic [fem_spi_pkg::DATA_W-1:0] rx_control_r;
  logic [fem_spi_pkg::DATA_W-1:0] otp_a_r;
  logic [fem_spi_pkg::DATA_W-1:0] otp_b_r;

  // Whether a register answers the serial port in the given state
  function automatic logic reachable(
    input logic [fem_spi_pkg::ADDR_W-1:0] a,
    input logic [fem_spi_pkg::ST_W-1:0] st
  );
    case (a)
      fem_spi_pkg::ADDR_TX_CTRL,
      fem_spi_pkg::ADDR_RX_CTRL:
        reachable = (st == fem_spi_pkg::ST_PROGRAM) ||
                    (st == fem_spi_pkg::ST_RECEIVE) ||
                    (st == fem_spi_pkg::ST_TRANSMIT) ||
                    (st == fem_spi_pkg::ST_OTP_PROG); // R14
      fem_spi_pkg::ADDR_OTP_A,
      fem_spi_pkg::ADDR_OTP_B:
        reachable = (st == fem_spi_pkg::ST_OTP_PROG); // R15
      fem_spi_pkg::ADDR_PART_CODE,
      fem_spi_pkg::ADDR_REVISION,
      fem_spi_pkg::ADDR_IDENT_LOW,
      fem_spi_pkg::ADDR_IDENT_HIGH:
        reachable = (st == fem_spi_pkg::ST_PROGRAM); // R16
      default:
        reachable = 1'b0;
    endcase
  endfunction

  // Release the reset through two flip-flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end

  assign rst_n = rst_pipe_r[1];

  spi_link u_link
  (
    .rst_n(rst_n),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .rd_word(rd_word_r),
    .addr_ready(addr_ready),
    .wr_toggle(wr_toggle),
    .cmd(cmd),
    .addr(addr),
    .wdata(wdata)
  );

  bit_sync u_ar_sync
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(addr_ready),
    .q(ar_sync)
  );

  bit_sync u_wt_sync
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(wr_toggle),
    .q(wt_sync)
  );

  // Edge detectors after the synchronisers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ar_last_r <= 1'b0;
      wt_last_r <= 1'b0;
    end
    else
    begin
      ar_last_r <= ar_sync;
      wt_last_r <= wt_sync;
    end
  end

  assign ar_evt = ar_sync & ~ar_last_r;
  assign wr_evt = wt_sync ^ wt_last_r;

  // Read mux; the open revision nibble answers in any state
  always_comb
  begin
    case (addr)
      fem_spi_pkg::ADDR_TX_CTRL: rd_word_nxt = tx_control_r;
      fem_spi_pkg::ADDR_RX_CTRL: rd_word_nxt = rx_control_r;
      fem_spi_pkg::ADDR_OTP_A: rd_word_nxt = otp_a_r;
      fem_spi_pkg::ADDR_OTP_B: rd_word_nxt = otp_b_r;
      fem_spi_pkg::ADDR_PART_CODE: rd_word_nxt = PART_CODE;
      fem_spi_pkg::ADDR_REVISION: rd_word_nxt = REVISION;
      fem_spi_pkg::ADDR_IDENT_LOW: rd_word_nxt = IDENT_LOW;
      fem_spi_pkg::ADDR_IDENT_HIGH: rd_word_nxt = IDENT_HIGH;
      default: rd_word_nxt = '0;
    endcase
    if (!reachable(addr, op_state))
    begin
      if (addr == fem_spi_pkg::ADDR_REVISION)
        rd_word_nxt = rd_word_nxt & fem_spi_pkg::REV_OPEN_MASK; // R16
      else
        rd_word_nxt = '0; // R18
    end
  end

  // Snapshot taken once the address is in, so a write frame shifts
  // out the value held before its own update
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_word_r <= '0;
    else if (ar_evt)
      rd_word_r <= rd_word_nxt; // R9 R11
  end

  // Register file; only a complete write frame to a reachable register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_control_r <= fem_spi_pkg::RESET_CFG;
      rx_control_r <= fem_spi_pkg::RESET_CFG;
      otp_a_r <= fem_spi_pkg::RESET_CFG;
      otp_b_r <= fem_spi_pkg::RESET_CFG;
    end
    else if (wr_evt && cmd == fem_spi_pkg::CMD_WRITE &&
             reachable(addr, op_state)) // R10 R17 R18
    begin
      case (addr)
        fem_spi_pkg::ADDR_TX_CTRL: tx_control_r <= wdata; // R10
        fem_spi_pkg::ADDR_RX_CTRL: rx_control_r <= wdata;
        fem_spi_pkg::ADDR_OTP_A: otp_a_r <= wdata; // R15
        fem_spi_pkg::ADDR_OTP_B: otp_b_r <= wdata;
        default: ;
      endcase
    end
  end

  assign tx_control = tx_control_r;
  assign rx_control = rx_control_r;
  assign otp_preset_a = otp_a_r;
  assign otp_preset_b = otp_b_r;

  AST_WRITE_TX: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && cmd == fem_spi_pkg::CMD_WRITE &&
     addr == fem_spi_pkg::ADDR_TX_CTRL && reachable(addr, op_state))
    |=> (tx_control_r == $past(wdata)))
    else $error("write frame did not update the addressed register");

  AST_OTHER_CMD_KEEPS: assert property ( // R17
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && cmd != fem_spi_pkg::CMD_WRITE) |=>
      ($stable(tx_control_r) && $stable(rx_control_r) &&
       $stable(otp_a_r) && $stable(otp_b_r)))
    else $error("non-write frame changed a register");

  AST_OTP_LOCKED: assert property ( // R15
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && op_state != fem_spi_pkg::ST_OTP_PROG &&
     (addr == fem_spi_pkg::ADDR_OTP_A || addr == fem_spi_pkg::ADDR_OTP_B))
    |=> ($stable(otp_a_r) && $stable(otp_b_r)))
    else $error("preset register written outside programming state");

  AST_READ_ZERO: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && !reachable(addr, op_state) &&
     addr != fem_spi_pkg::ADDR_REVISION) |=> (rd_word_r == 8'h00))
    else $error("unreachable register did not read as zero");

  AST_READ_TX: assert property ( // R9
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_TX_CTRL &&
     op_state == fem_spi_pkg::ST_TRANSMIT) |=>
      (rd_word_r == $past(tx_control_r)))
    else $error("read snapshot differs from register");

  AST_IDENT_PROGRAM: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_IDENT_LOW &&
     op_state == fem_spi_pkg::ST_PROGRAM) |=> (rd_word_r == IDENT_LOW))
    else $error("identity register not readable in program state");

  AST_WRITE_RX: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && cmd == fem_spi_pkg::CMD_WRITE &&
     addr == fem_spi_pkg::ADDR_RX_CTRL && reachable(addr, op_state))
    |=> (rx_control_r == $past(wdata)))
    else $error("write frame did not update the receive control");

  AST_OTP_WRITE: assert property ( // R15
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && cmd == fem_spi_pkg::CMD_WRITE &&
     addr == fem_spi_pkg::ADDR_OTP_A &&
     op_state == fem_spi_pkg::ST_OTP_PROG) |=> (otp_a_r == $past(wdata)))
    else $error("preset register not written in programming state");

  AST_CTRL_LOCKED: assert property ( // R14
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_evt && op_state == fem_spi_pkg::ST_POWER_DOWN &&
     (addr == fem_spi_pkg::ADDR_TX_CTRL || addr == fem_spi_pkg::ADDR_RX_CTRL))
    |=> ($stable(tx_control_r) && $stable(rx_control_r)))
    else $error("control register written in power-down");

  AST_REV_NIBBLE: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_REVISION &&
     op_state != fem_spi_pkg::ST_PROGRAM)
    |=> (rd_word_r == (REVISION & fem_spi_pkg::REV_OPEN_MASK)))
    else $error("revision upper nibble visible outside program state");

  AST_PART_PROGRAM: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_PART_CODE &&
     op_state == fem_spi_pkg::ST_PROGRAM) |=> (rd_word_r == PART_CODE))
    else $error("part code not readable in program state");

  AST_OTP_READ: assert property ( // R15
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_OTP_B &&
     op_state == fem_spi_pkg::ST_OTP_PROG) |=>
      (rd_word_r == $past(otp_b_r)))
    else $error("preset register not readable in programming state");

  AST_IDENT_LOCKED: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (ar_evt && addr == fem_spi_pkg::ADDR_IDENT_HIGH &&
     op_state != fem_spi_pkg::ST_PROGRAM) |=> (rd_word_r == 8'h00))
    else $error("identity register visible outside program state");

endmodule

// ==== verification/spi_host_model.sv ====
// Host model: SPI mode 0 master that runs one frame for each task call.
// Assumes the port samples mosi on rising edges and shifts on falling.
`timescale 1ns/1ps
module spi_host_model
(
  output logic sclk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b1;
  end

  // Sends n bits of w; a release before sixteen bits aborts the frame
  task automatic xfer(input logic [15:0] w, input int n,
    output logic [7:0] rx, output logic oe);
    int i;
    begin
      rx = 8'h00;
      #5;
      mosi = w[15];
      chip_select_n = 1'b0;
      #32;
      oe = miso_oe;
      for (i = 0; i < n; i++)
      begin
        if (i >= 8)
          rx = {rx[6:0], miso};
        sclk = 1'b1;
        #32;
        sclk = 1'b0;
        if (i < 15)
          mosi = w[14 - i];
        #32;
      end
      chip_select_n = 1'b1;
      // Released line shows the inverse of its last level
      mosi = ~mosi;
      #128;
    end
  endtask
endmodule

// ==== verification/fem_spi_register_port_bench.sv ====
// Self-checking bench for the serial register port.
// Assumes the host model makes the serial clock only within frames.
`timescale 1ns/1ps
module fem_spi_register_port_bench;
  // Identity values; arbitrary
  localparam logic [7:0] PART = 8'h96;
  localparam logic [7:0] REV = 8'hb7;
  localparam logic [7:0] ID_L = 8'h4e;
  localparam logic [7:0] ID_H = 8'he1;
  logic sys_clk;
  logic rstn;
  logic [fem_spi_pkg::ST_W-1:0] op_state;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic [7:0] outs [4];
  logic [7:0] shadow [4];
  logic [5:0] addrs [9];
  int fails;
  int tests_run;

  fem_spi_register_port #(.PART_CODE(PART), .REVISION(REV),
    .IDENT_LOW(ID_L), .IDENT_HIGH(ID_H)) fem_spi_register_port_i (
    .sys_clk(sys_clk), .rstn(rstn), .op_state(op_state), .sclk(sclk),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .tx_control(outs[0]), .rx_control(outs[1]),
    .otp_preset_a(outs[2]), .otp_preset_b(outs[3]));

  spi_host_model spi_host_model_i (.sclk(sclk),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  initial
  begin
    sys_clk = 1'b0;
  end
  always #2 sys_clk = ~sys_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
    input string msg);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %b", $time, msg, got);
    end
  endtask

  task automatic chk_regs();
    int i;
    for (i = 0; i < 4; i++)
      chk8(outs[i], shadow[i], "register output");
  endtask

  function automatic logic reach(input logic [5:0] a, input logic [2:0] s);
    if (a < 6'h02)
      return (s != fem_spi_pkg::ST_POWER_DOWN) &&
        (s <= fem_spi_pkg::ST_OTP_PROG);
    return s == fem_spi_pkg::ST_OTP_PROG;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [5:0] a,
    input logic [2:0] s);
    logic pg;
    pg = (s == fem_spi_pkg::ST_PROGRAM);
    if (a < 6'h04)
      return reach(a, s) ? shadow[a[1:0]] : 8'h00;
    if (a == fem_spi_pkg::ADDR_PART_CODE)
      return pg ? PART : 8'h00;
    if (a == fem_spi_pkg::ADDR_REVISION)
      return pg ? REV : (REV & fem_spi_pkg::REV_OPEN_MASK);
    if (a == fem_spi_pkg::ADDR_IDENT_LOW)
      return pg ? ID_L : 8'h00;
    if (a == fem_spi_pkg::ADDR_IDENT_HIGH)
      return pg ? ID_H : 8'h00;
    return 8'h00;
  endfunction

  task automatic set_state(input logic [2:0] s);
    @(posedge sys_clk);
    op_state <= s;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic frame(input logic [1:0] c, input logic [5:0] a,
    input logic [7:0] d, output logic [7:0] rx);
    logic oe;
    spi_host_model_i.xfer({c, a, d}, 16, rx, oe);
    chk1(oe, 1'b1, "miso_oe in frame");
    chk1(miso_oe, 1'b0, "miso_oe idle");
    chk1(miso, 1'b0, "miso idle");
  endtask

  task automatic t_write();
    logic [7:0] rx;
    set_state(fem_spi_pkg::ST_PROGRAM);
    frame(fem_spi_pkg::CMD_WRITE, 6'h00, 8'ha5, rx);
    chk8(rx, 8'h00, "writeback reset value");
    chk8(outs[0], 8'ha5, "write");
    frame(fem_spi_pkg::CMD_WRITE, 6'h00, 8'h5a, rx);
    chk8(rx, 8'ha5, "writeback previous");
    frame(fem_spi_pkg::CMD_READ, 6'h00, 8'hff, rx);
    chk8(rx, 8'h5a, "read data");
    chk8(outs[0], 8'h5a, "read leaves register");
    shadow[0] = 8'h5a;
    $display("test write done");
  endtask

  task automatic t_access();
    logic [7:0] rx;
    logic [7:0] v;
    int s;
    int k;
    for (s = 0; s < 5; s++)
    begin
      set_state(s[2:0]);
      for (k = 0; k < 9; k++)
      begin
        frame(fem_spi_pkg::CMD_READ, addrs[k], 8'h00, rx);
        chk8(rx, exp_rd(addrs[k], s[2:0]), "read");
      end
      for (k = 0; k < 4; k++)
      begin
        v = {s[3:0], k[3:0]} ^ 8'hc6;
        frame(fem_spi_pkg::CMD_WRITE, addrs[k], v, rx);
        chk8(rx, exp_rd(addrs[k], s[2:0]), "writeback");
        if (reach(addrs[k], s[2:0]))
          shadow[k] = v;
      end
      chk_regs();
    end
    $display("test access done");
  endtask

  task automatic t_other();
    logic [7:0] rx;
    int c;
    set_state(fem_spi_pkg::ST_PROGRAM);
    for (c = 0; c < 2; c++)
    begin
      frame(c[1:0], 6'h00, ~shadow[0], rx);
      chk_regs();
    end
    frame(fem_spi_pkg::CMD_WRITE, 6'h14, 8'h00, rx);
    chk8(rx, PART, "writeback read-only");
    frame(fem_spi_pkg::CMD_READ, 6'h14, 8'h00, rx);
    chk8(rx, PART, "read-only kept");
    $display("test other commands done");
  endtask

  task automatic t_abort();
    logic [7:0] rx;
    logic oe;
    spi_host_model_i.xfer({fem_spi_pkg::CMD_WRITE, 6'h01, ~shadow[1]},
      12, rx, oe);
    chk_regs();
    spi_host_model_i.xfer({fem_spi_pkg::CMD_WRITE, 6'h00, ~shadow[0]},
      15, rx, oe);
    chk_regs();
    frame(fem_spi_pkg::CMD_WRITE, 6'h01, 8'h42, rx);
    chk8(rx, shadow[1], "writeback after abort");
    shadow[1] = 8'h42;
    chk_regs();
    $display("test abort done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    fails = 0;
    tests_run = 0;
    shadow = '{8'h00, 8'h00, 8'h00, 8'h00};
    addrs = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h14, 6'h15, 6'h16, 6'h17,
      6'h3f};
    rstn = 1'b0;
    op_state = fem_spi_pkg::ST_POWER_DOWN;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk_regs();
    t_write();
    t_access();
    t_other();
    t_abort();
    wrap_up();
  end
endmodule
